//--- rtl/conv_ctrl_pkg.sv
package conv_ctrl_pkg;
    localparam int unsigned CLK_MHZ = 100;
    // Conversion length and track-return point, in clock cycles
    localparam int unsigned CONV_NS = 7800;
    localparam logic [9:0] CONV_CYCLES = 10'(CONV_NS * CLK_MHZ / 1000);
    // Track returns this many ns, less one clock cycle, before the conversion ends
    localparam int unsigned TRACK_LEAD_NS = 2000;
    localparam logic [9:0] TRACK_LEAD_CYCLES =
        10'((TRACK_LEAD_NS * CLK_MHZ + 999) / 1000);
    localparam logic [9:0] TRACK_AT = CONV_CYCLES - TRACK_LEAD_CYCLES;
    localparam int unsigned RESULT_W = 14;
    localparam int unsigned WORD_W = 16;
    localparam int unsigned BYTE_W = 8;
    localparam logic [1:0] PAD_ZERO = 2'h0;
    localparam logic [13:0] RESULT_RESET = 14'h0000;
    localparam logic [13:0] SIGN_FLIP = 14'h2000;
endpackage : conv_ctrl_pkg

//--- rtl/conv_ctrl.sv
// Summary of operation
// R1: Gated mode: start needs chip select and start low
// R2: Free mode: start falling edge starts, ignore select
// R3: Idle: done high, sample stage tracking
// R4: Start: hold sample, drive done low
// R5: Finish: done high, new result readable
// R6: Track again more than 2 us before end (code: hold falls 199 cycles, 1.99 us, before done rises)
// R7: Controller may switch channel once done falls
// R8: Data bytes driven when select and output enable low
// R9: Host waits recovery time after enable rises
// R10: Host must not hold start low continuously
// R11: Start strobe falls and stays low minimum width
// R12: Gated mode: select falling with start low starts
// R13: Free mode: done is open-drain under done enable
// R14: Gated mode: done driven under enable and select
// R15: All outputs float when not enabled
// R16: Read high byte then low, result left-justified
// R17: Unipolar straight binary, bipolar twos complement
// R18: Result register holds until next completion
// R19: Start during conversion is ignored
`timescale 1ns/100ps
`default_nettype none
module conv_ctrl (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic gated_mode_i,
    input wire logic chip_select_n_i,
    input wire logic start_convert_n_i,
    input wire logic output_enable_n_i,
    input wire logic done_output_enable_n_i,
    input wire logic high_byte_select_i,
    input wire logic bipolar_offset_pin_i,
    input wire logic [13:0] core_result_i,
    output logic hold_o,
    output logic done_o,
    output logic done_oe_n_o,
    output logic [7:0] data_byte_bus_o,
    output logic data_oe_n_o
);
    typedef enum logic {IDLE, CONVERTING} state_e;

    // Three-stage synchronisers; the first stage feeds only the second
    logic [2:0] cs_sync, sc_sync, oe_sync, done_output_enable_n_sync, hbe_sync;
    logic cs_n, sc_n, oe_n, done_output_enable_n_n, high_byte_select;
    logic [2:0] next_cs_sync, next_sc_sync, next_oe_sync;
    logic [2:0] next_done_output_enable_n_sync, next_hbe_sync;
    logic sc_fall, cs_fall, start_req;

    state_e state, next_state;
    logic [9:0] count, next_count;
    logic hold, next_hold;
    logic [13:0] result, next_result;
    logic bipolar, next_bipolar, bip_taken, next_bip_taken;
    logic done, next_done, done_oe_n, next_done_oe_n;
    logic [7:0] data_byte, next_data_byte;
    logic data_oe_n, next_data_oe_n;
    logic [15:0] word;

    always_comb begin
        next_cs_sync = {cs_sync[1:0], chip_select_n_i};
        next_sc_sync = {sc_sync[1:0], start_convert_n_i};
        next_oe_sync = {oe_sync[1:0], output_enable_n_i};
        next_done_output_enable_n_sync = {done_output_enable_n_sync[1:0], done_output_enable_n_i};
        next_hbe_sync = {hbe_sync[1:0], high_byte_select_i};
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            cs_sync <= 3'h7;
            sc_sync <= 3'h7;
            oe_sync <= 3'h7;
            done_output_enable_n_sync <= 3'h7;
            hbe_sync <= 3'h0;
            cs_n <= 1'b1;
            sc_n <= 1'b1;
            oe_n <= 1'b1;
            done_output_enable_n_n <= 1'b1;
            high_byte_select <= 1'b0;
        end else begin
            cs_sync <= next_cs_sync;
            sc_sync <= next_sc_sync;
            oe_sync <= next_oe_sync;
            done_output_enable_n_sync <= next_done_output_enable_n_sync;
            hbe_sync <= next_hbe_sync;
            // A level counts once stages two and three agree
            if (cs_sync[1] == cs_sync[2]) cs_n <= cs_sync[2];
            if (sc_sync[1] == sc_sync[2]) sc_n <= sc_sync[2];
            if (oe_sync[1] == oe_sync[2]) oe_n <= oe_sync[2];
            if (done_output_enable_n_sync[1] == done_output_enable_n_sync[2]) done_output_enable_n_n <= done_output_enable_n_sync[2];
            if (hbe_sync[1] == hbe_sync[2]) high_byte_select <= hbe_sync[2];
        end
    end

    assign sc_fall = sc_n && (sc_sync[1] == sc_sync[2]) && !sc_sync[2];
    assign cs_fall = cs_n && (cs_sync[1] == cs_sync[2]) && !cs_sync[2];

    always_comb begin
        if (gated_mode_i) begin
            // Start edge with select low, or select edge with start low
            start_req = (sc_fall && !cs_n) // [R1]
                || (cs_fall && !sc_n); // [R12]
        end else begin
            start_req = sc_fall; // [R2]
        end
    end

    always_comb begin
        next_state = state;
        next_count = count;
        next_hold = hold;
        next_result = result;
        case (state)
            IDLE: begin
                next_hold = 1'b0; // [R3]
                if (start_req) begin
                    next_state = CONVERTING;
                    next_hold = 1'b1; // [R4]
                    next_count = 10'h000;
                end
            end
            CONVERTING: begin
                // Further starts fall through unseen here [R19]
                next_count = count + 10'h001;
                if (count == conv_ctrl_pkg::TRACK_AT) begin
                    next_hold = 1'b0; // [R6]
                end
                if (count == conv_ctrl_pkg::CONV_CYCLES - 10'h001) begin
                    next_state = IDLE;
                    // Result latched only here, stable between reads [R18]
                    next_result = core_result_i ^ (bipolar ?
                        conv_ctrl_pkg::SIGN_FLIP :
                        conv_ctrl_pkg::RESULT_RESET); // [R17]
                end
            end
            default: begin
                next_state = IDLE;
                next_hold = 1'b0;
            end
        endcase
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            state <= IDLE;
            count <= 10'h000;
            hold <= 1'b0;
            result <= conv_ctrl_pkg::RESULT_RESET;
        end else begin
            state <= next_state;
            count <= next_count;
            hold <= next_hold;
            result <= next_result;
        end
    end

    // Bipolar strap caught once, at the first edge after reset release
    always_comb begin
        next_bip_taken = 1'b1;
        next_bipolar = bip_taken ? bipolar : bipolar_offset_pin_i;
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            bip_taken <= 1'b0;
            bipolar <= 1'b0;
        end else begin
            bip_taken <= next_bip_taken;
            bipolar <= next_bipolar;
        end
    end

    assign word = {result, conv_ctrl_pkg::PAD_ZERO}; // [R16]

    always_comb begin
        // Done low while converting, high otherwise [R4] [R5] [R3]
        next_done = (next_state == IDLE);
        if (gated_mode_i) begin
            next_done_oe_n = done_output_enable_n_n || cs_n; // [R14]
        end else begin
            // Open drain: only pull low, float otherwise [R13]
            next_done_oe_n = done_output_enable_n_n || next_done;
        end
        next_data_oe_n = cs_n || oe_n; // [R8] [R15]
        next_data_byte = high_byte_select ? word[7:0] : word[15:8]; // [R16]
    end

    always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
            done <= 1'b1;
            done_oe_n <= 1'b1;
            data_byte <= 8'h00;
            data_oe_n <= 1'b1;
        end else begin
            done <= next_done;
            done_oe_n <= next_done_oe_n;
            data_byte <= next_data_byte;
            data_oe_n <= next_data_oe_n;
        end
    end

    assign hold_o = hold;
    assign done_o = done;
    assign done_oe_n_o = done_oe_n;
    assign data_byte_bus_o = data_byte;
    assign data_oe_n_o = data_oe_n;
endmodule : conv_ctrl
`default_nettype wire

//--- test/conv_ctrl_sva.sv
`timescale 1ns/100ps
`default_nettype none
module conv_ctrl_sva (
    input wire logic mclk_i,
    input wire logic rst_n_i,
    input wire logic gated_mode_i,
    input wire logic start_convert_n_i,
    input wire logic output_enable_n_i,
    input wire logic done_output_enable_n_i,
    input wire logic high_byte_select_i,
    input wire logic hold_o,
    input wire logic done_o,
    input wire logic done_oe_n_o,
    input wire logic data_oe_n_o,
    input wire logic [7:0] data_byte_bus_o
);
    logic [9:0] low_cnt;
    logic [9:0] next_low_cnt;
    always_comb next_low_cnt = done_o ? 10'h0 : low_cnt + 10'h1;
    always_ff @(posedge mclk_i) low_cnt <= rst_n_i ? next_low_cnt : 10'h0;
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);
    property p_start; $fell(done_o) |-> hold_o && !$past(start_convert_n_i, 2);
    endproperty
    a_start: assert property (p_start) else $error("bad start");
    property p_len; $rose(done_o) |-> low_cnt == 10'h30c; endproperty
    a_len: assert property (p_len) else $error("bad length");
    property p_track; $fell(hold_o) |-> low_cnt == 10'h245; endproperty
    a_track: assert property (p_track) else $error("bad track");
    property p_idle; done_o |-> !hold_o; endproperty
    a_idle: assert property (p_idle) else $error("hold idle");
    property p_od; !gated_mode_i && !done_oe_n_o |-> !done_o; endproperty
    a_od: assert property (p_od) else $error("drives high");
    property p_den; done_output_enable_n_i [*6] |-> done_oe_n_o; endproperty
    a_den: assert property (p_den) else $error("done float");
    property p_doe; output_enable_n_i [*6] |-> data_oe_n_o; endproperty
    a_doe: assert property (p_doe) else $error("data float");
    property p_pad; high_byte_select_i [*6] ##0 !data_oe_n_o
        |-> data_byte_bus_o[1:0] == 2'h0; endproperty
    a_pad: assert property (p_pad) else $error("bad pad");
endmodule : conv_ctrl_sva
`default_nettype wire

//--- test/host_model.sv
`timescale 1ns/100ps
`default_nettype none
module host_model #(parameter int START_PULSE_WIDTH = 8) (
    input wire logic mclk_i,
    input wire logic go_i,
    output logic start_convert_n_o
);
    int cnt = 0;
    // One clean fall per request, never held low for back-to-back runs
    always @(posedge mclk_i) begin
        if (go_i && cnt == 0) cnt <= START_PULSE_WIDTH;
        else if (cnt != 0) cnt <= cnt - 1;
    end
    assign start_convert_n_o = (cnt == 0);
endmodule : host_model
`default_nettype wire

//--- test/testbench.sv
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic mclk_i = 0, rst_n_i = 0, gm = 1, cs = 0, oe = 1, den = 1;
    logic hbs = 0, bip = 0, go = 0;
    logic [13:0] raw = 14'h0;
    wire logic scn, hold, done, done_oe_n, data_oe_n;
    wire logic [7:0] data;
    int miscompares = 0, n_compared = 0, cycles = 0;
    always #5 mclk_i = ~mclk_i;
    host_model host_u (.mclk_i(mclk_i), .go_i(go), .start_convert_n_o(scn));
    conv_ctrl dut_u (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .gated_mode_i(gm),
        .chip_select_n_i(cs), .start_convert_n_i(scn),
        .output_enable_n_i(oe), .done_output_enable_n_i(den),
        .high_byte_select_i(hbs), .bipolar_offset_pin_i(bip),
        .core_result_i(raw), .hold_o(hold), .done_o(done),
        .done_oe_n_o(done_oe_n), .data_byte_bus_o(data),
        .data_oe_n_o(data_oe_n));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        #1 n_compared++;
        if (seen !== exp) begin
            miscompares++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
    endtask : tick
    task automatic wait_for(input logic v);
        for (int i = 0; i < 1000 && done !== v; i++) tick(1);
    endtask : wait_for
    task automatic start(input logic g, input logic b, input logic c);
        rst_n_i <= 0;
        gm <= g;
        bip <= b;
        cs <= c;
        tick(16);
        rst_n_i <= 1;
        tick(4);
        check(done, 1'b1);
        go <= 1;
        tick(1);
        go <= 0;
    endtask : start
    task automatic t_conv(input logic g, input logic b, input logic [13:0] r);
        logic [15:0] w;
        w = {r ^ (b ? 14'h2000 : 14'h0), 2'h0};
        raw <= ~r;
        start(g, b, !g);
        wait_for(0);
        // Channel switched once done falls; the finish must take the new one
        raw <= r;
        check({done, hold}, 8'h1);
        tick(20);
        go <= 1;
        den <= 0;
        tick(1);
        go <= 0;
        tick(6);
        check(done_oe_n, 1'b0);
        den <= 1;
        wait_for(1);
        check(done, 1'b1);
        raw <= ~r;
        cs <= 0;
        tick(8);
        oe <= 0;
        hbs <= 0;
        tick(6);
        check(data, w[15:8]);
        hbs <= 1;
        tick(6);
        check(data, w[7:0]);
        oe <= 1;
        tick(8);
        check(data_oe_n, 1'b1);
        $display("conversion test done");
    endtask : t_conv
    task automatic final_report;
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : final_report
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            final_report();
        end
    end
    initial begin
        start(1, 0, 1);
        tick(20);
        check(done, 1'b1);
        // Start already low when select falls still starts in gated mode
        go <= 1;
        tick(1);
        go <= 0;
        tick(1);
        cs <= 0;
        wait_for(0);
        check({done, hold}, 8'h1);
        wait_for(1);
        check(done, 1'b1);
        $display("refusal test done");
        t_conv(1, 0, 14'h2a5c);
        t_conv(0, 1, 14'h3fff);
        t_conv(1, 1, 14'h0001);
        final_report();
    end
endmodule : testbench
bind conv_ctrl conv_ctrl_sva chk_u (.*);
`default_nettype wire
